// ### inc/udc_pkg.sv
// package: shared constants and state codes of the up/down-converter input port
// ==========
// Summary of operation
// - every flop runs on the rising edge of the one core clock.
// - control reset clears control state; filter data memory keeps its contents.
// - a sample enters only when source valid and device ready are both high.
// - after reset, ready stays high until the first valid sample arrives.
// - afterwards ready pulses for one cycle, spaced at the input sample rate.
// - while input is late, queued output keeps draining downstream.
// - while input is late, no new sample starts processing.
// - the real sample input is used in down-converter builds only, width parameterised.
// - up-converter builds mix all carriers into one complex zero-centred composite.
// - down-converter builds may first shift a real Fs/4 composite to zero.
// - down-converter filters and decimates to baseband rate or a multiple.
// - down-converter shifts each carrier to baseband for demodulation.
// - carrier positions and gains are programmed, status is reported.
// - a wrongly placed packet end is ignored and raises a packet error.
// - output leaves only when output valid and output ready are both high.
// - a valid output sample is held until the receiver is ready or a control reset flushes the queue.
package udc_pkg;
	// ==========
	// clock and pacing
	localparam int CLK_HZ       = 25_000_000;
	localparam int IN_RATE_HZ   = 3_125_000;
	// one cycle for the accepting edge and one for the last count state
	localparam int PACE_LEAD    = 2;
	// ==========
	// default sizes
	localparam int IN_WIDTH     = 16;
	localparam int NUM_CARRIERS = 2;
	localparam int PHASE_WIDTH  = 16;
	localparam int GAIN_WIDTH   = 2;
	localparam int DECIM_LOG2   = 2;
	localparam int FIFO_DEPTH   = 16;
	localparam int QUAD_WIDTH   = 2;
	// ==========
	// input pacing states
	typedef enum logic [2:0] {
		UDC_FIRST = 3'h1,
		UDC_PACE  = 3'h2,
		UDC_OPEN  = 3'h4
	} udc_state_e;
endpackage

// ### rtl/udc_mem.sv
// filter history memory: registered read, never cleared
`timescale 1ns/100ps
module udc_mem #(
	parameter int W     = 32,
	parameter int DEPTH = 4
) (
	input  wire logic                     clk,
	input  wire logic                     we,
	input  wire logic [$clog2(DEPTH)-1:0] waddr,
	input  wire logic [W-1:0]             wdata,
	input  wire logic [$clog2(DEPTH)-1:0] raddr,
	output logic      [W-1:0]             rdata
);
	logic [W-1:0] mem [DEPTH];

	// no reset of any kind reaches the array
	always_ff @(posedge clk) begin
		rdata <= mem[raddr];
		if (we) begin
			mem[waddr] <= wdata;
		end
	end
endmodule // udc_mem

// ### rtl/udc_fifo.sv
// output FIFO with registered head word
`timescale 1ns/100ps
module udc_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 16
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         flush,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wr;
		logic [AW-1:0]           rd;
		logic [AW:0]             cnt;
		logic                    ov;
		logic [W-1:0]            od;
	} udc_fifo_s;

	udc_fifo_s r;
	udc_fifo_s next_r;
	logic      push;
	logic      take;
	logic      bypass;

	assign in_ready  = (r.cnt != (AW+1)'(DEPTH));
	assign out_valid = r.ov;
	assign out_data  = r.od;

	always_comb begin
		next_r = r;
		push   = in_valid & in_ready;
		take   = ~r.ov | out_ready;
		bypass = 1'b0;
		if (take) begin
			if (r.cnt != '0) begin
				next_r.od  = r.mem[r.rd];
				next_r.ov  = 1'b1;
				next_r.rd  = r.rd + AW'(1);
				next_r.cnt = r.cnt - (AW+1)'(1);
			end else if (push) begin
				next_r.od = in_data;
				next_r.ov = 1'b1;
				bypass    = 1'b1;
			end else begin
				next_r.ov = 1'b0;
			end
		end
		if (push && !bypass) begin
			next_r.mem[r.wr] = in_data;
			next_r.wr        = r.wr + AW'(1);
			next_r.cnt       = next_r.cnt + (AW+1)'(1);
		end
		if (flush) begin
			next_r.ov  = 1'b0;
			next_r.cnt = '0;
			next_r.wr  = '0;
			next_r.rd  = '0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end
endmodule // udc_fifo

// ### rtl/udc_converter.sv
// up/down-converter input port, pacing, mixing and output queue
`timescale 1ns/100ps
module udc_converter #(
	parameter int IN_WIDTH       = udc_pkg::IN_WIDTH,
	parameter int NUM_CARRIERS   = udc_pkg::NUM_CARRIERS,
	parameter int PHASE_WIDTH    = udc_pkg::PHASE_WIDTH,
	parameter int GAIN_WIDTH     = udc_pkg::GAIN_WIDTH,
	parameter int DECIM_LOG2     = udc_pkg::DECIM_LOG2,
	parameter int FIFO_DEPTH     = udc_pkg::FIFO_DEPTH,
	parameter int IN_RATE_HZ     = udc_pkg::IN_RATE_HZ,
	parameter bit DOWN_CONVERTER = 1'b1,
	parameter bit FS4_MIX        = 1'b1,
	localparam int CW = (NUM_CARRIERS > 1) ? $clog2(NUM_CARRIERS) : 1
) (
	input  wire logic                               MCLK,
	input  wire logic                               RST_N,
	input  wire logic                               CONTROL_RESET_LOW,
	input  wire logic                               IN_SAMPLE_VALID,
	output logic                                    IN_SAMPLE_READY,
	input  wire logic [IN_WIDTH-1:0]                IN_REAL_SAMPLE,
	input  wire logic [IN_WIDTH-1:0]                IN_I_SAMPLE,
	input  wire logic [IN_WIDTH-1:0]                IN_Q_SAMPLE,
	input  wire logic                               IN_PACKET_END,
	input  wire logic [NUM_CARRIERS*PHASE_WIDTH-1:0] CARRIER_STEP,
	input  wire logic [NUM_CARRIERS*GAIN_WIDTH-1:0]  CARRIER_GAIN,
	input  wire logic                               MISSING_INPUT_CLEAR,
	input  wire logic                               PACKET_ERROR_CLEAR,
	output logic                                    MISSING_INPUT_IRQ,
	output logic                                    PACKET_ERROR_IRQ,
	output logic                                    OUT_SAMPLE_VALID,
	input  wire logic                               OUT_SAMPLE_READY,
	output logic      [IN_WIDTH-1:0]                OUT_I_SAMPLE,
	output logic      [IN_WIDTH-1:0]                OUT_Q_SAMPLE,
	output logic      [CW-1:0]                      OUT_CARRIER,
	output logic                                    OUT_PACKET_END
);
	// ==========
	// derived sizes
	// the period rounds down: unless a full queue stalls it, the device never asks slower than the set rate
	localparam int IN_PERIOD = udc_pkg::CLK_HZ / IN_RATE_HZ;
	localparam int PW        = $clog2(IN_PERIOD + 1);
	localparam int GW        = (DECIM_LOG2 > CW) ? DECIM_LOG2 : CW;
	localparam int AW        = IN_WIDTH + GW;
	localparam int DW        = 2 * IN_WIDTH;
	localparam int FW        = DW + CW + 1;
	localparam int QW        = udc_pkg::QUAD_WIDTH;

	localparam logic [PW-1:0]         PACE_LOAD = PW'(IN_PERIOD - udc_pkg::PACE_LEAD);
	localparam logic [CW-1:0]         PKT_LAST  = CW'(DOWN_CONVERTER ? 0 : NUM_CARRIERS - 1);
	localparam logic [CW-1:0]         CAR_LAST  = CW'(NUM_CARRIERS - 1);
	localparam logic [DECIM_LOG2-1:0] PTR_LAST  = '1;

	// ==========
	// state
	typedef struct packed {
		udc_pkg::udc_state_e                       state;
		logic                                      ready;
		logic [PW-1:0]                             pace;
		logic                                      miss;
		logic                                      perr;
		logic [CW-1:0]                             pkt;
		logic [QW-1:0]                             quad;
		logic                                      pend;
		logic [IN_WIDTH-1:0]                       new_i;
		logic [IN_WIDTH-1:0]                       new_q;
		logic [DECIM_LOG2-1:0]                     ptr;
		logic                                      primed;
		logic [AW-1:0]                             acc_i;
		logic [AW-1:0]                             acc_q;
		logic [IN_WIDTH-1:0]                       res_i;
		logic [IN_WIDTH-1:0]                       res_q;
		logic                                      emit;
		logic [CW-1:0]                             idx;
		logic [NUM_CARRIERS-1:0][PHASE_WIDTH-1:0]  phase;
	} udc_conv_s;

	localparam udc_conv_s ST_RESET = '{
		state: udc_pkg::UDC_FIRST,
		ready: 1'b1,
		default: '0
	};

	udc_conv_s r;
	udc_conv_s next_r;

	// ==========
	// quarter-turn rotation: multiplies by j to the power quad
	function automatic logic [DW-1:0] rotate(
		input logic [IN_WIDTH-1:0] i,
		input logic [IN_WIDTH-1:0] q,
		input logic [QW-1:0]       quad
	);
		logic [IN_WIDTH-1:0] ni;
		logic [IN_WIDTH-1:0] nq;
		ni = (~i) + IN_WIDTH'(1);
		nq = (~q) + IN_WIDTH'(1);
		case (quad)
			2'h0: rotate = {i, q};
			2'h1: rotate = {nq, i};
			2'h2: rotate = {ni, nq};
			default: rotate = {q, ni};
		endcase
	endfunction

	// ==========
	// per-carrier programming and baseband shift
	logic [PHASE_WIDTH-1:0] step   [NUM_CARRIERS];
	logic [GAIN_WIDTH-1:0]  gain   [NUM_CARRIERS];
	logic [IN_WIDTH-1:0]    mix_i  [NUM_CARRIERS];
	logic [IN_WIDTH-1:0]    mix_q  [NUM_CARRIERS];

	for (genvar c = 0; c < NUM_CARRIERS; c++) begin : g_car
		logic [QW-1:0] back;
		logic [DW-1:0] rv;
		assign step[c]  = CARRIER_STEP[c*PHASE_WIDTH +: PHASE_WIDTH];
		assign gain[c]  = CARRIER_GAIN[c*GAIN_WIDTH +: GAIN_WIDTH];
		// coarse quadrant mixer: the phase top bits pick the rotation
		assign back     = (~r.phase[c][PHASE_WIDTH-1 -: QW]) + QW'(1);
		assign rv       = rotate(r.res_i, r.res_q, back);
		assign mix_i[c] = IN_WIDTH'($signed(rv[DW-1:IN_WIDTH]) >>> gain[c]);
		assign mix_q[c] = IN_WIDTH'($signed(rv[IN_WIDTH-1:0]) >>> gain[c]);
	end

	// ==========
	// filter memory and output queue
	logic [DW-1:0] old_word;
	logic          fifo_ready;
	logic          fifo_valid;
	logic [FW-1:0] fifo_data;
	logic [FW-1:0] head;

	udc_mem #(
		.W     (DW),
		.DEPTH (1 << DECIM_LOG2)
	) u_mem (
		.clk   (MCLK),
		.we    (r.pend),
		.waddr (r.ptr),
		.wdata ({r.new_i, r.new_q}),
		.raddr (r.ptr),
		.rdata (old_word)
	);

	// control reset empties the queue so stale carriers never mix with new ones
	udc_fifo #(
		.W     (FW),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (MCLK),
		.rst_n     (RST_N),
		.flush     (~CONTROL_RESET_LOW),
		.in_valid  (fifo_valid),
		.in_ready  (fifo_ready),
		.in_data   (fifo_data),
		.out_valid (OUT_SAMPLE_VALID),
		.out_ready (OUT_SAMPLE_READY),
		.out_data  (head)
	);

	assign OUT_PACKET_END  = head[FW-1];
	assign OUT_CARRIER     = head[DW +: CW];
	assign OUT_I_SAMPLE    = head[IN_WIDTH +: IN_WIDTH];
	assign OUT_Q_SAMPLE    = head[IN_WIDTH-1:0];
	assign IN_SAMPLE_READY   = r.ready;
	assign MISSING_INPUT_IRQ = r.miss;
	assign PACKET_ERROR_IRQ  = r.perr;

	// ==========
	// next-state logic
	logic          accept;
	logic          busy;
	logic          exp_end;
	logic [DW-1:0] in_word;
	logic [DW-1:0] up_word;
	logic [DW-1:0] hist;
	logic [AW-1:0] sum_i;
	logic [AW-1:0] sum_q;

	always_comb begin
		next_r     = r;
		accept     = r.ready & IN_SAMPLE_VALID;
		busy       = r.pend | r.emit;
		exp_end    = (r.pkt == PKT_LAST);
		in_word    = rotate(IN_REAL_SAMPLE, '0,
			FS4_MIX ? QW'((~r.quad) + QW'(1)) : QW'(0));
		up_word    = rotate(IN_I_SAMPLE, IN_Q_SAMPLE,
			r.phase[r.pkt][PHASE_WIDTH-1 -: QW]);
		// history is garbage until the window is written once; a running sum never
		// forgets such an offset, so it counts as zero until then
		hist       = r.primed ? old_word : DW'(0);
		sum_i      = '0;
		sum_q      = '0;
		fifo_valid = r.emit;
		if (DOWN_CONVERTER) begin
			fifo_data = {r.idx == CAR_LAST, r.idx, mix_i[r.idx], mix_q[r.idx]};
		end else begin
			fifo_data = {1'b1, CW'(0), r.res_i, r.res_q};
		end

		// input pacing
		case (r.state)
			udc_pkg::UDC_FIRST: begin
				next_r.ready = 1'b1;
				if (accept) begin
					next_r.state = udc_pkg::UDC_PACE;
					next_r.ready = 1'b0;
					next_r.pace  = PACE_LOAD;
				end
			end
			udc_pkg::UDC_PACE: begin
				if (r.pace != '0) begin
					next_r.pace = r.pace - PW'(1);
				end else if (!busy) begin
					// a full queue stretches the gap and so reaches the source
					next_r.state = udc_pkg::UDC_OPEN;
					next_r.ready = 1'b1;
				end
			end
			udc_pkg::UDC_OPEN: begin
				if (accept) begin
					next_r.state = udc_pkg::UDC_PACE;
					next_r.ready = 1'b0;
					next_r.pace  = PACE_LOAD;
				end else begin
					next_r.ready = 1'b1;
				end
			end
			default: begin
				next_r.state = udc_pkg::UDC_FIRST;
				next_r.ready = 1'b1;
			end
		endcase

		// sticky flags, a new event beats a clear in the same cycle
		next_r.miss = (r.miss & ~MISSING_INPUT_CLEAR) |
			((r.state == udc_pkg::UDC_OPEN) & r.ready & ~IN_SAMPLE_VALID);
		next_r.perr = r.perr & ~PACKET_ERROR_CLEAR;

		// packet framing follows the count; a wrong flag is only reported
		if (accept) begin
			if (IN_PACKET_END != exp_end) begin
				next_r.perr = 1'b1;
			end
			next_r.pkt = exp_end ? '0 : r.pkt + CW'(1);
		end

		if (DOWN_CONVERTER) begin
			if (accept) begin
				next_r.new_i = in_word[DW-1:IN_WIDTH];
				next_r.new_q = in_word[IN_WIDTH-1:0];
				next_r.pend  = 1'b1;
				next_r.quad  = r.quad + QW'(1);
			end
			if (r.pend) begin
				// moving sum over the decimation window, then keep every Nth
				sum_i = r.acc_i + AW'($signed(r.new_i)) -
					AW'($signed(hist[DW-1:IN_WIDTH]));
				sum_q = r.acc_q + AW'($signed(r.new_q)) -
					AW'($signed(hist[IN_WIDTH-1:0]));
				next_r.acc_i = sum_i;
				next_r.acc_q = sum_q;
				next_r.ptr   = r.ptr + DECIM_LOG2'(1);
				next_r.pend  = 1'b0;
				if (r.ptr == PTR_LAST) begin
					next_r.primed = 1'b1;
					next_r.res_i = sum_i[DECIM_LOG2 +: IN_WIDTH];
					next_r.res_q = sum_q[DECIM_LOG2 +: IN_WIDTH];
					next_r.emit  = 1'b1;
					next_r.idx   = '0;
				end
			end
			if (r.emit && fifo_ready) begin
				next_r.phase[r.idx] = r.phase[r.idx] + step[r.idx];
				next_r.idx          = r.idx + CW'(1);
				if (r.idx == CAR_LAST) begin
					next_r.emit = 1'b0;
				end
			end
		end else begin
			if (accept) begin
				// one packet carries one sample per carrier, summed into one composite
				sum_i = (r.pkt == '0 ? AW'(0) : r.acc_i) +
					AW'($signed(up_word[DW-1:IN_WIDTH]) >>> gain[r.pkt]);
				sum_q = (r.pkt == '0 ? AW'(0) : r.acc_q) +
					AW'($signed(up_word[IN_WIDTH-1:0]) >>> gain[r.pkt]);
				next_r.acc_i        = sum_i;
				next_r.acc_q        = sum_q;
				next_r.phase[r.pkt] = r.phase[r.pkt] + step[r.pkt];
				if (exp_end) begin
					next_r.res_i = sum_i[CW +: IN_WIDTH];
					next_r.res_q = sum_q[CW +: IN_WIDTH];
					next_r.emit  = 1'b1;
				end
			end
			if (r.emit && fifo_ready) begin
				next_r.emit = 1'b0;
			end
		end

		// control reset: filter history, window sum and pointer are data, kept
		if (!CONTROL_RESET_LOW) begin
			next_r.state = udc_pkg::UDC_FIRST;
			next_r.ready = 1'b1;
			next_r.pace  = '0;
			next_r.miss  = 1'b0;
			next_r.perr  = 1'b0;
			next_r.pkt   = '0;
			next_r.quad  = '0;
			next_r.pend  = 1'b0;
			next_r.emit  = 1'b0;
			next_r.idx   = '0;
			next_r.phase = '0;
		end
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			r <= ST_RESET;
		end else begin
			r <= next_r;
		end
	end
endmodule // udc_converter

// ### test/udc_converter_assertions.sv
// checker: port-level properties of the converter input pacing, flags and output queue
`timescale 1ns/100ps
module udc_converter_assertions #(
	parameter int IN_WIDTH = 16,
	parameter int CW       = 1
) (
	input wire logic                MCLK,
	input wire logic                RST_N,
	input wire logic                CONTROL_RESET_LOW,
	input wire logic                IN_SAMPLE_VALID,
	input wire logic                IN_SAMPLE_READY,
	input wire logic                IN_PACKET_END,
	input wire logic                MISSING_INPUT_CLEAR,
	input wire logic                MISSING_INPUT_IRQ,
	input wire logic                PACKET_ERROR_IRQ,
	input wire logic                OUT_SAMPLE_VALID,
	input wire logic                OUT_SAMPLE_READY,
	input wire logic [IN_WIDTH-1:0] OUT_I_SAMPLE,
	input wire logic [CW-1:0]       OUT_CARRIER,
	input wire logic                OUT_PACKET_END
);
	// ==========
	// helper state
	logic seen;
	logic take;
	logic late;
	assign take = IN_SAMPLE_VALID && IN_SAMPLE_READY;
	assign late = seen && IN_SAMPLE_READY && !IN_SAMPLE_VALID && CONTROL_RESET_LOW;
	// a take during control reset is discarded, so it must not open pacing
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			seen <= 1'b0;
		end else begin
			seen <= CONTROL_RESET_LOW && (seen || take);
		end
	end
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_N);
	// ==========
	// properties
	property p_first_open;
		!seen |-> IN_SAMPLE_READY;
	endproperty
	a_first_open: assert property (p_first_open) else $error("ready low before first take");
	property p_pace;
		disable iff (!RST_N || !CONTROL_RESET_LOW)
		take |=> !IN_SAMPLE_READY [*7];
	endproperty
	a_pace: assert property (p_pace) else $error("ready back too early");
	property p_wait_open;
		late |=> IN_SAMPLE_READY && MISSING_INPUT_IRQ;
	endproperty
	a_wait_open: assert property (p_wait_open) else $error("late input not held or flagged");
	property p_miss_keep;
		MISSING_INPUT_IRQ && !MISSING_INPUT_CLEAR && CONTROL_RESET_LOW |=> MISSING_INPUT_IRQ;
	endproperty
	a_miss_keep: assert property (p_miss_keep) else $error("missing flag lost");
	property p_miss_clear;
		MISSING_INPUT_CLEAR && !late |=> !MISSING_INPUT_IRQ;
	endproperty
	a_miss_clear: assert property (p_miss_clear) else $error("missing flag not cleared");
	property p_pkt_err;
		$rose(PACKET_ERROR_IRQ) |-> $past(take) && !$past(IN_PACKET_END);
	endproperty
	a_pkt_err: assert property (p_pkt_err) else $error("packet error without bad end");
	property p_ctl_reset;
		!CONTROL_RESET_LOW
		|=> IN_SAMPLE_READY && !OUT_SAMPLE_VALID && !MISSING_INPUT_IRQ && !PACKET_ERROR_IRQ;
	endproperty
	a_ctl_reset: assert property (p_ctl_reset) else $error("control reset incomplete");
	property p_out_hold;
		OUT_SAMPLE_VALID && !OUT_SAMPLE_READY && CONTROL_RESET_LOW
		|=> OUT_SAMPLE_VALID && $stable(OUT_CARRIER) && $stable(OUT_PACKET_END)
			&& OUT_I_SAMPLE === $past(OUT_I_SAMPLE);
	endproperty
	a_out_hold: assert property (p_out_hold) else $error("output word changed while held");
	property p_out_order;
		OUT_SAMPLE_VALID && OUT_SAMPLE_READY && OUT_CARRIER == '0 && CONTROL_RESET_LOW
		|=> !OUT_SAMPLE_VALID || (OUT_CARRIER == CW'(1) && OUT_PACKET_END);
	endproperty
	a_out_order: assert property (p_out_order) else $error("carrier order broken");
endmodule // udc_converter_assertions

bind udc_converter udc_converter_assertions #(
	.IN_WIDTH(IN_WIDTH),
	.CW      (CW)
) udc_converter_assertions_inst (
	.MCLK,
	.RST_N,
	.CONTROL_RESET_LOW,
	.IN_SAMPLE_VALID,
	.IN_SAMPLE_READY,
	.IN_PACKET_END,
	.MISSING_INPUT_CLEAR,
	.MISSING_INPUT_IRQ,
	.PACKET_ERROR_IRQ,
	.OUT_SAMPLE_VALID,
	.OUT_SAMPLE_READY,
	.OUT_I_SAMPLE,
	.OUT_CARRIER,
	.OUT_PACKET_END
);

// ### test/udc_source.sv
// upstream sample source: offers samples up to a limit, with a chosen idle gap
`timescale 1ns/100ps
module udc_source #(
	parameter int W = 16
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        ready,
	input  wire logic [15:0] limit,
	input  wire logic [7:0]  gap,
	input  wire logic        end_flag,
	output logic             valid,
	output logic [W-1:0]     sample,
	output logic             pkt_end
);
	logic        took;
	logic [15:0] taken;
	logic [7:0]  idle;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			took <= 1'b0;
		end else begin
			took <= valid && ready;
		end
	end
	// released lines toggle so a stale word can never pass for a held one
	always @(negedge clk or negedge rst_n) begin
		if (!rst_n) begin
			valid <= 1'b0;
			sample <= '0;
			pkt_end <= 1'b0;
			taken <= 16'h0;
			idle <= 8'h0;
		end else if (took) begin
			valid <= 1'b0;
			sample <= ~sample;
			pkt_end <= ~pkt_end;
			taken <= taken + 16'h1;
			idle <= gap;
		end else if (!valid && idle == 8'h0 && taken < limit) begin
			valid <= 1'b1;
			sample <= W'({taken[7:0], 8'h5A});
			pkt_end <= end_flag;
		end else if (!valid) begin
			sample <= ~sample;
			pkt_end <= ~pkt_end;
			if (idle != 8'h0) begin
				idle <= idle - 8'h1;
			end
		end
	end
endmodule // udc_source

// ### test/updown_converter_input_port_tb_top.sv
// testbench: input pacing, missing input, packet error, output queue and control reset
`timescale 1ns/100ps
module updown_converter_input_port_tb_top;
	localparam int W = udc_pkg::IN_WIDTH;
	logic          mclk;
	logic          rst_n;
	logic          ctl_rst_n;
	logic          miss_clr;
	logic          perr_clr;
	logic          out_ready;
	logic [31:0]   step;
	logic [3:0]    gain;
	logic [15:0]   takes;
	logic [15:0]   src_limit;
	logic [7:0]    src_gap;
	logic          src_end;
	logic          in_valid;
	logic          in_ready;
	logic [W-1:0]  in_real;
	logic          in_end;
	logic          miss_irq;
	logic          perr_irq;
	logic          out_valid;
	logic [0:0]    out_car;
	logic [W-1:0]  out_i;
	logic [W-1:0]  out_q;
	logic          out_end;
	int            err_total;
	int            tests_run;

	udc_converter udc_converter_inst (
		.MCLK(mclk), .RST_N(rst_n), .CONTROL_RESET_LOW(ctl_rst_n),
		.IN_SAMPLE_VALID(in_valid), .IN_SAMPLE_READY(in_ready), .IN_REAL_SAMPLE(in_real),
		.IN_I_SAMPLE(16'h0), .IN_Q_SAMPLE(16'h0), .IN_PACKET_END(in_end),
		.CARRIER_STEP(step), .CARRIER_GAIN(gain),
		.MISSING_INPUT_CLEAR(miss_clr), .PACKET_ERROR_CLEAR(perr_clr),
		.MISSING_INPUT_IRQ(miss_irq), .PACKET_ERROR_IRQ(perr_irq),
		.OUT_SAMPLE_VALID(out_valid), .OUT_SAMPLE_READY(out_ready),
		.OUT_I_SAMPLE(out_i), .OUT_Q_SAMPLE(out_q), .OUT_CARRIER(out_car),
		.OUT_PACKET_END(out_end)
	);
	udc_source udc_source_inst (
		.clk(mclk), .rst_n(rst_n), .ready(in_ready), .limit(src_limit), .gap(src_gap),
		.end_flag(src_end), .valid(in_valid), .sample(in_real), .pkt_end(in_end)
	);

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			takes <= 16'h0;
		end else if (in_valid === 1'b1 && in_ready === 1'b1) begin
			takes <= takes + 16'h1;
		end
	end
	// ==========
	// shared tasks
	task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic cyc(int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic take_n(int n);
		logic [15:0] t;
		t = takes + 16'(n);
		src_limit <= t;
		for (int i = 0; i < 100 * n && takes < t; i++) @(negedge mclk);
		if (takes < t) begin
			err_total++;
			complete_run();
		end
	endtask
	// ==========
	// scenarios
	task automatic t_first_open();
		cyc(20);
		check("ready before first", in_ready, 16'h1);
		check("flag before first", miss_irq, 16'h0);
	endtask
	task automatic t_pacing();
		int i;
		take_n(1);
		// the source now waits ahead of each ready pulse, so no sample is late
		src_limit <= takes + 16'h3;
		for (int k = 0; k < 3; k++) begin
			check("ready drop", in_ready, 16'h0);
			i = 0;
			while (in_ready !== 1'b1 && i < 20) begin
				@(negedge mclk);
				i++;
			end
			check("ready gap", 16'(i), 16'h7);
			@(negedge mclk);
			check("one-cycle ready", in_ready, 16'h0);
		end
		check("no flag on time", miss_irq, 16'h0);
		// first window after reset: samples 005A..035A, quarter-rate mix, sum over four
		cyc(2);
		check("carrier 0 i", out_i, 16'hFF80);
		check("carrier 0 q", out_q, 16'h0080);
		cyc(1);
		check("carrier 1 i", out_i, 16'hFFC0);
		check("carrier 1 q", out_q, 16'h0040);
	endtask
	task automatic t_missing();
		src_gap <= 8'h1E;
		take_n(1);
		cyc(12);
		check("ready held", in_ready, 16'h1);
		check("missing flag", miss_irq, 16'h1);
		miss_clr <= 1'b1;
		cyc(1);
		miss_clr <= 1'b0;
		check("set beats clear", miss_irq, 16'h1);
		src_gap <= 8'h0;
		take_n(1);
		cyc(2);
		check("flag sticky", miss_irq, 16'h1);
		miss_clr <= 1'b1;
		cyc(1);
		miss_clr <= 1'b0;
		cyc(1);
		check("flag cleared", miss_irq, 16'h0);
	endtask
	task automatic t_output();
		int n;
		n = 0;
		cyc(12);
		out_ready <= 1'b0;
		take_n(8);
		cyc(12);
		check("word waits", out_valid, 16'h1);
		check("input waits", in_ready, 16'h1);
		out_ready <= 1'b1;
		for (int k = 0; k < 12; k++) begin
			if (out_valid === 1'b1) begin
				check("carrier", out_car, 16'(n % 2));
				check("packet end", out_end, 16'(n % 2));
				n++;
			end
			@(negedge mclk);
		end
		check("words drained", 16'(n), 16'h4);
		check("queue empty", out_valid, 16'h0);
		check("still waiting", in_ready, 16'h1);
	endtask
	task automatic t_pkt_err();
		src_end <= 1'b0;
		take_n(1);
		check("packet error", perr_irq, 16'h1);
		src_end <= 1'b1;
		perr_clr <= 1'b1;
		cyc(1);
		perr_clr <= 1'b0;
		check("error cleared", perr_irq, 16'h0);
		take_n(1);
		check("good end", perr_irq, 16'h0);
	endtask
	task automatic t_ctl_reset();
		out_ready <= 1'b0;
		take_n(4);
		cyc(10);
		check("queued", out_valid, 16'h1);
		check("flag up", miss_irq, 16'h1);
		ctl_rst_n <= 1'b0;
		cyc(1);
		ctl_rst_n <= 1'b1;
		check("ready reopened", in_ready, 16'h1);
		check("queue flushed", out_valid, 16'h0);
		check("flag reset", miss_irq, 16'h0);
		cyc(12);
		check("first state quiet", miss_irq, 16'h0);
		out_ready <= 1'b1;
		take_n(1);
		check("paced again", in_ready, 16'h0);
	endtask
	// ==========
	// main sequence
	initial begin
		err_total = 0;
		tests_run = 0;
		rst_n = 1'b0;
		ctl_rst_n = 1'b1;
		miss_clr = 1'b0;
		perr_clr = 1'b0;
		out_ready = 1'b1;
		step = 32'h40001000;
		gain = 4'h4;
		src_limit = 16'h0;
		src_gap = 8'h0;
		src_end = 1'b1;
		cyc(16);
		rst_n = 1'b1;
		t_first_open();
		t_pacing();
		t_missing();
		t_output();
		t_pkt_err();
		t_ctl_reset();
		complete_run();
	end
endmodule // updown_converter_input_port_tb_top
